/* File: cdb_pkg.sv */
package cdb_pkg;
  localparam int WORD_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 13;
  localparam int KIMM_W = 11;
  // opcode fields
  localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
  localparam logic [5:0] OPC_DECSKIP = 6'h0B;
  localparam logic [2:0] OPC_BRANCH = 3'h5;
  localparam int OPC6_LSB = 8;
  localparam int OPC3_LSB = 11;
  localparam int DEST_BIT = 7;
  // upper target latch field
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;

  typedef struct packed {
    logic en;
    logic toFile;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cdb_wr_s;

  typedef enum logic [1:0] {
    CDB_EXEC,
    CDB_FLUSH
  } cdb_state_e;
endpackage : cdb_pkg

/* File: cdb_exec.sv */
`timescale 1ns/1ps
// Overview of operation
// - complement word inverts the addressed register, updates zero flag, one cycle.
// - complement destination bit 0 selects accumulator, 1 selects file register.
// - decrement-skip subtracts one from addressed register, flags untouched.
// - decrement-skip destination bit 0 selects accumulator, 1 selects file register.
// - zero decrement result discards the already fetched next instruction.
// - skip runs an idle cycle instead, so two cycles when skipping.
// - branch loads 11-bit immediate into program counter bits 10 to 0.
// - branch fills counter bits 12 and 11 from latch bits 4 and 3.
// - branch takes one word and two cycles; the second lasts until the next valid word arrives.
module cdb_exec
  import cdb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // fetch stage
  input wire logic [WORD_W-1:0] instrWord,
  input wire logic instrValid,
  // operand source
  input wire logic [DATA_W-1:0] fileRdData,
  input wire logic [DATA_W-1:0] upperTargetLatch,
  output logic [FADDR_W-1:0] fileRdAddr,
  // results
  output cdb_wr_s wrOut,
  output logic [DATA_W-1:0] accumQ,
  output logic zeroFlagQ,
  output logic [PC_W-1:0] pcQ,
  output logic flushQ
);
  // decoded fields of the word in the execute slot
  cdb_state_e state_q;
  cdb_state_e state_d;
  logic isComp;
  logic isDec;
  logic isBranch;
  logic execOk;
  logic fileOp;
  logic destFile;
  logic writeFile;
  logic writeAccum;
  logic takeBranch;
  logic [FADDR_W-1:0] operandAddr;
  logic [KIMM_W-1:0] branchImm;
  // page bits sit above the branch immediate
  logic [PC_W-KIMM_W-1:0] pageBits;

  // shared datapath
  logic [DATA_W-1:0] result;
  logic resultZero;
  logic skipNext;

  // next values of the output registers
  logic flush_d;
  cdb_wr_s wr_d;
  logic [DATA_W-1:0] accum_d;
  logic zeroFlag_d;
  logic [PC_W-1:0] pc_d;
  logic [FADDR_W-1:0] rdAddr_d;

  // operand data comes back combinationally from the file, addressed straight from the word
  // opcode compares are exact, so any other word only advances the counter
  assign isComp = (instrWord[WORD_W-1:OPC6_LSB] == OPC_COMPLEMENT);
  assign isDec = (instrWord[WORD_W-1:OPC6_LSB] == OPC_DECSKIP);
  assign isBranch = (instrWord[WORD_W-1:OPC3_LSB] == OPC_BRANCH);
  assign execOk = instrValid && (state_q == CDB_EXEC);
  assign fileOp = isComp || isDec;
  assign destFile = instrWord[DEST_BIT];
  assign operandAddr = instrWord[FADDR_W-1:0];
  assign branchImm = instrWord[KIMM_W-1:0];
  assign pageBits = upperTargetLatch[LATCH_HI:LATCH_LO];
  assign writeFile = execOk && fileOp && destFile;
  assign writeAccum = execOk && fileOp && !destFile;
  assign takeBranch = execOk && isBranch;

  // one result path for both file operations; the opcode picks invert or decrement
  always_comb begin
    if (isComp) begin
      result = ~fileRdData;
    end else begin
      result = fileRdData - DATA_ONE;
    end
  end

  // an all-zero result feeds both the flag and the skip
  assign resultZero = (result == DATA_ZERO);
  assign skipNext = execOk && isDec && resultZero;

  // a flushed slot executes nothing, which is the idle cycle
  // the flush waits for a valid word, so a stalled fetch cannot lose the discard
  always_comb begin
    state_d = state_q;
    flush_d = flushQ;
    unique case (state_q)
      CDB_EXEC: begin
        if (skipNext || takeBranch) begin
          state_d = CDB_FLUSH;
          flush_d = 1'b1;
        end else begin
          flush_d = 1'b0;
        end
      end
      CDB_FLUSH: begin
        if (instrValid) begin
          state_d = CDB_EXEC;
          flush_d = 1'b0;
        end
      end
      // unused codes of the state register fall back to executing
      default: begin
        state_d = CDB_EXEC;
        flush_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= CDB_EXEC;
    end else begin
      state_q <= state_d;
    end
  end

  // kept apart from the state so the port is a plain flop
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flushQ <= 1'b0;
    end else begin
      flushQ <= flush_d;
    end
  end

  // address and data hold after the pulse; only en marks a write
  always_comb begin
    wr_d = wrOut;
    wr_d.en = 1'b0;
    if (writeFile) begin
      wr_d.en = 1'b1;
      wr_d.toFile = 1'b1;
      wr_d.addr = operandAddr;
      wr_d.data = result;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wrOut <= '0;
    end else begin
      wrOut <= wr_d;
    end
  end

  // the accumulator only moves on a file operation aimed at it
  always_comb begin
    accum_d = accumQ;
    if (writeAccum) begin
      accum_d = result;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      accumQ <= DATA_ZERO;
    end else begin
      accumQ <= accum_d;
    end
  end

  // decrement-skip leaves the zero flag alone
  always_comb begin
    zeroFlag_d = zeroFlagQ;
    if (execOk && isComp) begin
      zeroFlag_d = resultZero;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      zeroFlagQ <= 1'b0;
    end else begin
      zeroFlagQ <= zeroFlag_d;
    end
  end

  // counter follows the fetch stream; a flushed slot still advances past the discarded word
  // it wraps at the top of program space, as the fetch address does
  always_comb begin
    pc_d = pcQ;
    if (takeBranch) begin
      pc_d = {pageBits, branchImm};
    end else if (instrValid) begin
      pc_d = pcQ + PC_ONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pcQ <= PC_RESET;
    end else begin
      pcQ <= pc_d;
    end
  end

  // last file operand taken, for the file side to see which register moved
  // a branch or a discarded word leaves it as it was
  always_comb begin
    rdAddr_d = fileRdAddr;
    if (execOk && fileOp) begin
      rdAddr_d = operandAddr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fileRdAddr <= '0;
    end else begin
      fileRdAddr <= rdAddr_d;
    end
  end
endmodule : cdb_exec

/* File: cdb_exec_asserts.sv */
`timescale 1ns/1ps
module cdb_exec_asserts
  import cdb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // fetch and operands
  input wire logic [WORD_W-1:0] instrWord,
  input wire logic instrValid,
  input wire logic [DATA_W-1:0] fileRdData,
  input wire logic [DATA_W-1:0] upperTargetLatch,
  // results
  input wire logic [FADDR_W-1:0] fileRdAddr,
  input wire cdb_wr_s wrOut,
  input wire logic [DATA_W-1:0] accumQ,
  input wire logic zeroFlagQ,
  input wire logic [PC_W-1:0] pcQ,
  input wire logic flushQ
);
  wire logic take = instrValid && !flushQ;
  wire logic comp = take && instrWord[13:8] == OPC_COMPLEMENT;
  wire logic dec = take && instrWord[13:8] == OPC_DECSKIP;
  wire logic br = take && instrWord[13:11] == OPC_BRANCH;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  comp_file_a: assert property (comp && instrWord[7] |=> wrOut.en && wrOut.data == ~$past(fileRdData))
    else $error("complement write wrong");
  comp_accum_a: assert property (comp && !instrWord[7] |=> accumQ == ~$past(fileRdData) && !wrOut.en)
    else $error("complement accumulator wrong");
  comp_zero_a: assert property (comp |=> zeroFlagQ == ($past(fileRdData) == 8'hff))
    else $error("zero flag wrong");
  dec_file_a: assert property (dec && instrWord[7] |=> wrOut.data == $past(fileRdData) - 8'h01)
    else $error("decrement write wrong");
  dec_flags_a: assert property (dec |=> $stable(zeroFlagQ))
    else $error("decrement touched flag");
  dec_skip_a: assert property (dec |=> flushQ == ($past(fileRdData) == 8'h01))
    else $error("skip decision wrong");
  br_target_a: assert property (br |=> flushQ && pcQ == {$past(upperTargetLatch[4:3]), $past(instrWord[10:0])})
    else $error("branch target wrong");
  flush_idle_a: assert property (flushQ && instrValid |=> !flushQ && !wrOut.en && pcQ == $past(pcQ) + PC_ONE)
    else $error("discarded word had effect");
  dec_accum_a: assert property (dec && !instrWord[7] |=> accumQ == $past(fileRdData) - 8'h01 && !wrOut.en)
    else $error("decrement accumulator wrong");
  rd_addr_a: assert property ((comp || dec) |=> fileRdAddr == $past(instrWord[6:0]))
    else $error("operand address wrong");
  cover property (dec ##1 flushQ);
  cover property (br ##1 flushQ);
  cover property (comp && instrWord[7]);
endmodule : cdb_exec_asserts
bind cdb_exec cdb_exec_asserts cdb_exec_asserts_inst (.*);

/* File: cdb_file_model.sv */
`timescale 1ns/1ps
module cdb_file_model
  import cdb_pkg::*;
(
  // file port
  input wire logic sys_clk,
  input wire logic [FADDR_W-1:0] rdAddr,
  input wire cdb_wr_s wrIn,
  output logic [DATA_W-1:0] rdData
);
  logic [DATA_W-1:0] mem [128];
  // odd seeds so address 0 decrements to zero and 127 complements to zero
  initial for (int i = 0; i < 128; i++) mem[i] = {i[6:0], 1'b1};
  assign rdData = mem[rdAddr];
  always @(posedge sys_clk) if (wrIn.en && wrIn.toFile) mem[wrIn.addr] <= wrIn.data;
endmodule : cdb_file_model

/* File: complement_decskip_branch_exec_test.sv */
`timescale 1ns/1ps
module complement_decskip_branch_exec_test;
  import cdb_pkg::*;
  logic sys_clk = 0, sys_rst = 1, instrValid = 0;
  logic [WORD_W-1:0] instrWord = '0;
  logic [DATA_W-1:0] latch = 8'h18, rdData, accumQ;
  logic [PC_W-1:0] pcQ;
  logic zeroFlagQ, flushQ;
  logic [FADDR_W-1:0] fileRdAddr;
  cdb_wr_s wrOut;
  int failures = 0, n_checks = 0;
  always #25 sys_clk = ~sys_clk;
  cdb_exec cdb_exec_inst (.sys_clk, .sys_rst, .instrWord, .instrValid, .fileRdData(rdData),
    .upperTargetLatch(latch), .fileRdAddr, .wrOut, .accumQ, .zeroFlagQ, .pcQ, .flushQ);
  cdb_file_model cdb_file_model_inst (.sys_clk, .rdAddr(instrWord[6:0]), .wrIn(wrOut), .rdData);
  task automatic chk(input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // one idle cycle between words keeps a flush waiting for the next word
  task automatic issue(input logic [WORD_W-1:0] w);
    @(posedge sys_clk) instrWord <= w;
    instrValid <= 1'b1;
    @(posedge sys_clk) instrValid <= 1'b0;
    #1;
  endtask : issue
  task automatic complement_case;
    issue(14'h0985);
    chk({wrOut.en, wrOut.toFile, wrOut.data, zeroFlagQ}, 11'h7e8);
    chk({accumQ, fileRdAddr}, 15'h0005);
    issue(14'h097f);
    chk({wrOut.en, accumQ, zeroFlagQ}, 10'h001);
  endtask : complement_case
  task automatic decskip_case;
    issue(14'h0b02);
    chk({accumQ, zeroFlagQ, flushQ}, 10'h012);
    issue(14'h0b80);
    chk({wrOut.en, wrOut.data, flushQ}, 10'h201);
    issue(14'h0985);
    chk({wrOut.en, flushQ, fileRdAddr}, 9'h000);
  endtask : decskip_case
  task automatic branch_case;
    issue(14'h2fff);
    chk({flushQ, pcQ}, 14'h3fff);
    issue(14'h0985);
    chk({flushQ, pcQ, wrOut.en}, 15'h0000);
    @(posedge sys_clk) latch <= 8'h17;
    issue(14'h2801);
    chk({flushQ, pcQ}, 14'h3001);
  endtask : branch_case
  // reset lands while a flush is pending; the first word after it must execute
  task automatic reset_case;
    @(posedge sys_clk) sys_rst <= 1'b1;
    @(posedge sys_clk) sys_rst <= 1'b0;
    #1;
    chk({wrOut.en, zeroFlagQ, flushQ, fileRdAddr}, 10'h000);
    chk({accumQ, wrOut.data}, 16'h0000);
    chk(pcQ, 13'h0000);
    issue(14'h0b80);
    chk({wrOut.en, wrOut.data, flushQ}, 10'h3fe);
    chk(pcQ, 13'h0001);
  endtask : reset_case
  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    complement_case();
    decskip_case();
    branch_case();
    reset_case();
    final_report();
  end
endmodule : complement_decskip_branch_exec_test
